// ==== rtl/dss_sequencer.sv ====
// Summary of operation
// - clock edge sets the switch; a trip clears it until the next edge
// - reference enabled once supply is above the lockout threshold, or by over-temperature during lockout
// - reference good starts oscillator and begins pulling the gate low
// - weak gate pull-down first, strong pull-down once the gate is low
// - supply below threshold sets fault and pulls the gate high hard
// - shutdown low disables everything; release starts power-up
// - fault latch clears only by shutdown toggle or reset; supply dropping below lockout does not clear it
// - lockout check runs first after shutdown release
// - negative regulator enabled together with the main regulator
// - positive regulator enabled only after soft-start completes
// - fault timer held inactive during soft-start
// - soft-start ramps the reference over 4096 oscillator cycles
// - soft-start reference is a 5-bit value in 32 equal steps
// - frequency select low gives 500 kHz, high gives 1 MHz
// - input overcurrent counts as a fault event
// - after soft-start a low output or overcurrent runs the fault timer
// - fault held for 64 ms sets the fault latch, reference stays on
// - over-temperature sets the same fault latch
`timescale 1ns/1ps
module dss_sequencer import dss_pkg::*; #(
  parameter int unsigned FAULT_CYCLES = DSS_FAULT_CYCLES,
  // shorter periods only so that simulation can reach the end of soft-start
  parameter logic [8:0]  OSC_LAST_HI  = DSS_OSC_LAST_HI,
  parameter logic [8:0]  OSC_LAST_LO  = DSS_OSC_LAST_LO
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       shutdownNInput,
  input  wire logic       frequencySelect,
  input  wire logic       supplyAboveLockout,
  input  wire logic       referenceGood,
  input  wire logic       gateLowDetect,
  input  wire logic       pwmTrip,
  input  wire logic       overcurrentTrip,
  input  wire logic       overTemp,
  input  wire logic       mainOutputLow,
  input  wire logic       posOutputLow,
  input  wire logic       negOutputLow,
  output logic            lockoutEnable,
  output logic            referenceEnable,
  output logic            oscillatorEnable,
  output logic            gateWeakPullDown,
  output logic            gateStrongPullDown,
  output logic            gateStrongPullUp,
  output logic            powerSwitchOn,
  output logic            mainEnable,
  output logic            negEnable,
  output logic            posEnable,
  output logic [4:0]      softStartRef,
  output logic            faultLatched,
  output logic            faultTimerRunning
);

  localparam logic [23:0] FAULT_LAST = 24'(FAULT_CYCLES - 1);

  typedef struct packed {
    dss_state_t  st;
    logic [8:0]  oscCnt;
    logic [11:0] ssCnt;
    logic [23:0] faultCnt;
    logic        uvloEn;
    logic        refEn;
    logic        oscEn;
    logic        weakDn;
    logic        strongDn;
    logic        strongUp;
    logic        sw;
    logic        mainEn;
    logic        negEn;
    logic        posEn;
    logic [4:0]  ssRef;
    logic        fault;
    logic        timerRun;
  } dss_core_t;

  dss_core_t            r_reg;
  dss_core_t            r_next;
  logic [DSS_NIN-1:0]   syncIn;
  logic [DSS_NIN-1:0]   rawIn;

  assign rawIn = {negOutputLow, posOutputLow, mainOutputLow, overTemp,
                  overcurrentTrip, pwmTrip, gateLowDetect, referenceGood,
                  supplyAboveLockout, frequencySelect, shutdownNInput};

  dss_input_sync #(.W(DSS_NIN)) uSync (
    .clk   (clk),
    .reset (reset),
    .din   (rawIn),
    .dout  (syncIn)
  );

  logic       shdnS;
  logic       supOkS;
  logic       tripS;
  logic       faultCond;
  logic       tick;
  logic       active;
  logic [8:0] oscLast;

  assign shdnS  = syncIn[DSS_I_SHUTDOWN_N_INPUT];
  assign supOkS = syncIn[DSS_I_SUPOK];
  assign tripS  = syncIn[DSS_I_TRIP];
  assign faultCond = syncIn[DSS_I_MAINL] | syncIn[DSS_I_POSL] |
                     syncIn[DSS_I_NEGL] | syncIn[DSS_I_OC];
  // rate selection; soft-start length follows automatically
  assign oscLast = syncIn[DSS_I_FREQUENCY_SELECT] ? OSC_LAST_HI
                                      : OSC_LAST_LO;
  assign tick   = r_reg.oscEn && (r_reg.oscCnt >= oscLast);
  assign active = (r_reg.st == DSS_REF) || (r_reg.st == DSS_GATE) ||
                  (r_reg.st == DSS_SOFT) || (r_reg.st == DSS_RUN);

  always_comb begin
    r_next          = r_reg;
    r_next.timerRun = 1'b0;
    r_next.oscCnt   = (!r_reg.oscEn || tick) ? 9'h000 : r_reg.oscCnt + 9'h001;
    case (r_reg.st)
      DSS_OFF: begin
        if (shdnS) begin
          r_next.st = DSS_SUPPLY_LOW_LOCKOUT;
        end
      end
      DSS_SUPPLY_LOW_LOCKOUT: begin
        if (supOkS) begin
          r_next.st = DSS_REF;
        end
      end
      DSS_REF: begin
        if (syncIn[DSS_I_REFOK]) begin
          r_next.st = DSS_GATE;
        end
      end
      DSS_GATE: begin
        r_next.ssCnt = 12'h000;
        if (syncIn[DSS_I_GLOW]) begin
          r_next.st = DSS_SOFT;
        end
      end
      DSS_SOFT: begin
        if (tick) begin
          r_next.ssCnt = r_reg.ssCnt + 12'h001;
          if (r_reg.ssCnt == DSS_SS_LAST) begin
            r_next.st = DSS_RUN;
          end
        end
      end
      DSS_RUN: begin
        // any break in the fault condition restarts the full timeout
        if (faultCond) begin
          r_next.timerRun = 1'b1;
          r_next.faultCnt = r_reg.faultCnt + 24'h00_0001;
          if (r_reg.faultCnt >= FAULT_LAST) begin
            r_next.st = DSS_FAULT;
          end
        end else begin
          r_next.faultCnt = 24'h00_0000;
        end
      end
      DSS_FAULT: begin
        r_next.st = DSS_FAULT;
      end
      default: begin
        r_next.st = DSS_OFF;
      end
    endcase
    if (active && !supOkS) begin
      r_next.st = DSS_FAULT;
    end
    if (syncIn[DSS_I_OT] && (r_reg.st != DSS_OFF)) begin
      r_next.st = DSS_FAULT;
    end
    if (!shdnS) begin
      r_next.st = DSS_OFF;
    end
    if (r_next.st != DSS_RUN) begin
      r_next.faultCnt = 24'h00_0000;
      r_next.timerRun = 1'b0;
    end
    if ((r_next.st != DSS_SOFT) && (r_next.st != DSS_RUN)) begin
      r_next.ssCnt = 12'h000;
    end

    r_next.uvloEn   = (r_next.st != DSS_OFF);
    r_next.refEn    = (r_next.st != DSS_OFF) && (r_next.st != DSS_SUPPLY_LOW_LOCKOUT);
    r_next.oscEn    = (r_next.st == DSS_GATE) || (r_next.st == DSS_SOFT) ||
                      (r_next.st == DSS_RUN);
    r_next.weakDn   = (r_next.st == DSS_GATE);
    r_next.strongDn = (r_next.st == DSS_SOFT) || (r_next.st == DSS_RUN);
    r_next.strongUp = !r_next.oscEn;
    r_next.mainEn   = r_next.strongDn;
    r_next.negEn    = r_next.strongDn;
    r_next.posEn    = (r_next.st == DSS_RUN);
    r_next.fault    = (r_next.st == DSS_FAULT);
    if (r_next.st == DSS_RUN) begin
      r_next.ssRef = DSS_REF_FULL;
    end else if (r_next.st == DSS_SOFT) begin
      r_next.ssRef = r_next.ssCnt[11:7];
    end else begin
      r_next.ssRef = DSS_REF_ZERO;
    end
    // set on the oscillator edge wins; otherwise a trip holds it off
    if (!r_next.mainEn) begin
      r_next.sw = 1'b0;
    end else if (tick) begin
      r_next.sw = 1'b1;
    end else if (tripS) begin
      r_next.sw = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r_reg          <= '0;
      r_reg.st       <= DSS_OFF;
      r_reg.strongUp <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign lockoutEnable      = r_reg.uvloEn;
  assign referenceEnable    = r_reg.refEn;
  assign oscillatorEnable   = r_reg.oscEn;
  assign gateWeakPullDown   = r_reg.weakDn;
  assign gateStrongPullDown = r_reg.strongDn;
  assign gateStrongPullUp   = r_reg.strongUp;
  assign powerSwitchOn      = r_reg.sw;
  assign mainEnable         = r_reg.mainEn;
  assign negEnable          = r_reg.negEn;
  assign posEnable          = r_reg.posEn;
  assign softStartRef       = r_reg.ssRef;
  assign faultLatched       = r_reg.fault;
  assign faultTimerRunning  = r_reg.timerRun;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_step_edge;
    (r_reg.st == DSS_SOFT) && tick && (r_reg.ssCnt[6:0] == DSS_STEP_LAST)
      && (r_reg.ssCnt != DSS_SS_LAST) && shdnS && supOkS
      && !syncIn[DSS_I_OT];
  endsequence

  sequence s_timeout;
    (r_reg.st == DSS_RUN) && faultCond && (r_reg.faultCnt >= FAULT_LAST)
      && shdnS;
  endsequence

  a_switch_trip_off: assert property (
    (r_reg.sw && tripS && !tick) |=> !powerSwitchOn)
    else $error("switch stayed on after comparator trip");
  a_ref_after_lock: assert property (
    $rose(referenceEnable) |-> $past(supOkS) && lockoutEnable)
    else $error("reference enabled without supply above lockout");
  a_osc_after_ref: assert property (
    $rose(oscillatorEnable)
      |-> $past(syncIn[DSS_I_REFOK]) && referenceEnable)
    else $error("oscillator started before reference good");
  a_gate_strong_seq: assert property (
    $rose(gateStrongPullDown)
      |-> $past(gateWeakPullDown) && !gateWeakPullDown)
    else $error("strong pull-down without weak phase");
  a_supply_low_lockout_fault_up: assert property (
    (active && !supOkS && shdnS) |=> faultLatched && gateStrongPullUp)
    else $error("supply loss did not latch fault");
  a_shutdown_n_input_all_off: assert property (
    !shdnS |=> !referenceEnable && !faultLatched && !mainEnable)
    else $error("shutdown did not disable outputs");
  a_fault_sticky: assert property (
    (faultLatched && shdnS) |=> faultLatched && referenceEnable)
    else $error("fault latch cleared without shutdown");
  a_neg_with_main: assert property (
    negEnable == mainEnable)
    else $error("negative regulator not enabled with main");
  a_pos_after_ss: assert property (
    $rose(posEnable) |-> $past(r_reg.ssCnt == DSS_SS_LAST)
      ##0 softStartRef == DSS_REF_FULL)
    else $error("positive regulator enabled before soft-start end");
  a_timer_idle_ss: assert property (
    (r_reg.st == DSS_SOFT)
      |-> !faultTimerRunning && (r_reg.faultCnt == 24'h00_0000))
    else $error("fault timer active during soft-start");
  a_ss_step_up: assert property (
    s_step_edge |=> softStartRef == $past(softStartRef) + 5'h01)
    else $error("soft-start step did not advance");
  a_timer_runs: assert property (
    ((r_reg.st == DSS_RUN) && faultCond && shdnS && supOkS
      && !syncIn[DSS_I_OT] && (r_reg.faultCnt < FAULT_LAST))
      |=> faultTimerRunning)
    else $error("fault timer idle with fault present");
  a_fault_timeout: assert property (
    s_timeout |=> faultLatched ##1 !mainEnable && referenceEnable)
    else $error("fault timeout did not latch");

endmodule

// ==== common/dss_pkg.sv ====
package dss_pkg;

  // oscillator derived from the 250 MHz system clock
  localparam int unsigned DSS_CLK_HZ      = 250_000_000;
  localparam int unsigned DSS_OSC_HI_KHZ  = 1_000;
  localparam int unsigned DSS_OSC_LO_KHZ  = 500;
  localparam int unsigned DSS_DIV_HI      =
    DSS_CLK_HZ / (DSS_OSC_HI_KHZ * 1_000);
  localparam int unsigned DSS_DIV_LO      =
    DSS_CLK_HZ / (DSS_OSC_LO_KHZ * 1_000);
  localparam logic [8:0]  DSS_OSC_LAST_HI = 9'(DSS_DIV_HI - 1);
  localparam logic [8:0]  DSS_OSC_LAST_LO = 9'(DSS_DIV_LO - 1);

  // soft-start: 4096 oscillator cycles, 32 steps of 128 cycles
  localparam int unsigned DSS_SS_CYCLES   = 4_096;
  localparam int unsigned DSS_SS_STEPS    = 32;
  localparam int unsigned DSS_SS_STEP_LEN = DSS_SS_CYCLES / DSS_SS_STEPS;
  localparam logic [11:0] DSS_SS_LAST     = 12'(DSS_SS_CYCLES - 1);
  localparam logic [6:0]  DSS_STEP_LAST   = 7'(DSS_SS_STEP_LEN - 1);
  localparam logic [4:0]  DSS_REF_FULL    = 5'h1f;
  localparam logic [4:0]  DSS_REF_ZERO    = 5'h00;

  // fault timer
  localparam int unsigned DSS_FAULT_MS     = 64;
  localparam int unsigned DSS_FAULT_CYCLES = DSS_CLK_HZ / 1_000 * DSS_FAULT_MS;

  // indices of the synchronised input vector
  localparam int unsigned DSS_NIN     = 11;
  localparam int unsigned DSS_I_SHUTDOWN_N_INPUT  = 0;
  localparam int unsigned DSS_I_FREQUENCY_SELECT  = 1;
  localparam int unsigned DSS_I_SUPOK = 2;
  localparam int unsigned DSS_I_REFOK = 3;
  localparam int unsigned DSS_I_GLOW  = 4;
  localparam int unsigned DSS_I_TRIP  = 5;
  localparam int unsigned DSS_I_OC    = 6;
  localparam int unsigned DSS_I_OT    = 7;
  localparam int unsigned DSS_I_MAINL = 8;
  localparam int unsigned DSS_I_POSL  = 9;
  localparam int unsigned DSS_I_NEGL  = 10;

  typedef enum logic [2:0] {
    DSS_OFF   = 3'b000,
    DSS_SUPPLY_LOW_LOCKOUT  = 3'b001,
    DSS_REF   = 3'b010,
    DSS_GATE  = 3'b011,
    DSS_SOFT  = 3'b100,
    DSS_RUN   = 3'b101,
    DSS_FAULT = 3'b110
  } dss_state_t;

endpackage

// ==== rtl/dss_input_sync.sv ====
`timescale 1ns/1ps
module dss_input_sync import dss_pkg::*; #(
  parameter int unsigned W = DSS_NIN
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } dss_sync_t;

  dss_sync_t r_reg;
  dss_sync_t r_next;

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always_comb begin
    r_next    = r_reg;
    r_next.s1 = din;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.q  = (r_reg.s2 & r_reg.s3) |
                (~(r_reg.s2 ^ r_reg.s3) & r_reg.s2) |
                ((r_reg.s2 ^ r_reg.s3) & r_reg.q);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign dout = r_reg.q;

endmodule

// ==== verification/dss_analog_model.sv ====
`timescale 1ns/1ps
// stands for the reference, the gate node of the input switch and the pwm
// comparator; each answers after a fixed delay so the sequencing is visible
module dss_analog_model #(
  parameter int unsigned REF_DELAY  = 10,
  parameter int unsigned GATE_DELAY = 20,
  parameter int unsigned ON_TIME    = 40
) (
  input  wire logic clk,
  input  wire logic referenceEnable,
  input  wire logic gateWeakPullDown,
  input  wire logic gateStrongPullUp,
  input  wire logic powerSwitchOn,
  output logic      referenceGood,
  output logic      gateLowDetect,
  output logic      pwmTrip
);
  int refCnt = 0;
  int gateCnt = 0;
  int onCnt = 0;

  initial begin
    referenceGood = 1'b0;
    gateLowDetect = 1'b0;
    pwmTrip = 1'b0;
  end

  always @(posedge clk) begin
    refCnt <= referenceEnable ? refCnt + 1 : 0;
    referenceGood <= referenceEnable && refCnt >= REF_DELAY;
    // gate charge is lost only through the weak pull-down; the strong pull-up restores it
    if (gateStrongPullUp) begin
      gateCnt <= 0;
    end else if (gateWeakPullDown) begin
      gateCnt <= gateCnt + 1;
    end
    gateLowDetect <= !gateStrongPullUp && gateCnt >= GATE_DELAY;
    // inductor current ramps while the switch is on, trips after ON_TIME
    onCnt <= powerSwitchOn ? onCnt + 1 : 0;
    pwmTrip <= powerSwitchOn && onCnt >= ON_TIME;
  end
endmodule

// ==== verification/tb_dss_sequencer.sv ====
`timescale 1ns/1ps
module tb_dss_sequencer import dss_pkg::*;;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic shutdownNInput = 1'b0;
  logic frequencySelect = 1'b1;
  logic supplyAboveLockout = 1'b0;
  logic overcurrentTrip = 1'b0;
  logic overTemp = 1'b0;
  logic mainOutputLow = 1'b0;
  logic posOutputLow = 1'b0;
  logic negOutputLow = 1'b0;
  logic referenceGood, gateLowDetect, pwmTrip;
  logic lockoutEnable, referenceEnable, oscillatorEnable, gateWeakPullDown;
  logic gateStrongPullDown, gateStrongPullUp, powerSwitchOn, mainEnable;
  logic negEnable, posEnable, faultLatched, faultTimerRunning;
  logic [4:0] softStartRef;
  int error_cnt = 0;
  int check_count = 0;
  int took;
  // oscillator periods in clocks, matching the divider settings below
  localparam int P_HI = 16;
  localparam int P_LO = 32;
  localparam int ON_T = 2;

  always #2 clk = ~clk;

  dss_sequencer #(
    .FAULT_CYCLES (50),
    .OSC_LAST_HI  (9'h00f),
    .OSC_LAST_LO  (9'h01f)
  ) DUT (
    .clk(clk), .reset(reset), .shutdownNInput(shutdownNInput),
    .frequencySelect(frequencySelect),
    .supplyAboveLockout(supplyAboveLockout),
    .referenceGood(referenceGood), .gateLowDetect(gateLowDetect),
    .pwmTrip(pwmTrip), .overcurrentTrip(overcurrentTrip), .overTemp(overTemp),
    .mainOutputLow(mainOutputLow), .posOutputLow(posOutputLow),
    .negOutputLow(negOutputLow), .lockoutEnable(lockoutEnable),
    .referenceEnable(referenceEnable), .oscillatorEnable(oscillatorEnable),
    .gateWeakPullDown(gateWeakPullDown),
    .gateStrongPullDown(gateStrongPullDown),
    .gateStrongPullUp(gateStrongPullUp), .powerSwitchOn(powerSwitchOn),
    .mainEnable(mainEnable), .negEnable(negEnable), .posEnable(posEnable),
    .softStartRef(softStartRef), .faultLatched(faultLatched),
    .faultTimerRunning(faultTimerRunning));

  dss_analog_model #(.ON_TIME(ON_T)) analog (
    .clk(clk), .referenceEnable(referenceEnable),
    .gateWeakPullDown(gateWeakPullDown), .gateStrongPullUp(gateStrongPullUp),
    .powerSwitchOn(powerSwitchOn), .referenceGood(referenceGood),
    .gateLowDetect(gateLowDetect), .pwmTrip(pwmTrip));

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic pick(input int which);
    case (which)
      0: pick = lockoutEnable;
      1: pick = referenceEnable;
      2: pick = oscillatorEnable;
      3: pick = gateStrongPullDown;
      4: pick = faultLatched;
      5: pick = powerSwitchOn;
      6: pick = !powerSwitchOn;
      7: pick = posEnable;
      default: pick = (softStartRef === 5'h01);
    endcase
  endfunction

  task automatic wait_hi(input int which, input int lim, output int n);
    n = 0;
    while (pick(which) !== 1'b1) begin
      if (n >= lim) begin
        error_cnt++;
        $display("[FAIL] wait %0d expired", which);
        give_verdict();
      end
      tick(1);
      n++;
    end
  endtask

  task automatic bring_up();
    int n;
    shutdownNInput = 1'b1;
    wait_hi(0, 20, n);
    tick(20);
    check("ref before supply", referenceEnable, 0);
    supplyAboveLockout = 1'b1;
    wait_hi(1, 20, n);
    check("osc before refGood", oscillatorEnable, 0);
    wait_hi(2, 40, n);
    check("weak pull", gateWeakPullDown, 1);
    check("pull-up off", gateStrongPullUp, 0);
    check("strong early", gateStrongPullDown, 0);
    wait_hi(3, 60, n);
    check("weak off", gateWeakPullDown, 0);
    check("main on", mainEnable, 1);
    check("neg with main", negEnable, 1);
    check("ref start", softStartRef, 0);
    check("pos in soft", posEnable, 0);
  endtask

  task automatic measure(input int exp);
    int n;
    int onT;
    int offT;
    wait_hi(6, 600, n);
    wait_hi(5, 600, n);
    wait_hi(6, 600, onT);
    wait_hi(5, 600, offT);
    check("period", onT + offT, exp);
    check("on time", onT >= ON_T && onT <= ON_T + 8, 1);
  endtask

  initial begin
    tick(6);
    reset = 1'b0;
    check("pull-up in reset", gateStrongPullUp, 1);
    tick(10);
    check("lockout in shutdown_n_input", lockoutEnable, 0);
    bring_up();
    wait_hi(9, 130 * P_HI, took);
    check("step len", took >= 127 * P_HI
          && took <= 128 * P_HI + 8, 1);
    mainOutputLow = 1'b1;
    overcurrentTrip = 1'b1;
    tick(80);
    check("timer in soft", faultTimerRunning, 0);
    check("fault in soft", faultLatched, 0);
    check("pos in soft 2", posEnable, 0);
    mainOutputLow = 1'b0;
    overcurrentTrip = 1'b0;
    measure(P_HI);
    wait_hi(7, 4096 * P_HI, took);
    check("ss length", took >= 3900 * P_HI
          && took <= 3968 * P_HI, 1);
    check("ref full", softStartRef, DSS_REF_FULL);
    check("timer after ss", faultTimerRunning, 0);
    frequencySelect = 1'b0;
    tick(4 * P_LO);
    measure(P_LO);
    mainOutputLow = 1'b1;
    tick(20);
    check("timer runs", faultTimerRunning, 1);
    check("no early fault", faultLatched, 0);
    mainOutputLow = 1'b0;
    tick(10);
    check("timer restarts", faultTimerRunning, 0);
    overcurrentTrip = 1'b1;
    wait_hi(4, 80, took);
    check("fault delay", took >= 50 && took <= 60, 1);
    tick(2);
    check("ref kept", referenceEnable, 1);
    check("main off", mainEnable, 0);
    check("pos off", posEnable, 0);
    check("gate up", gateStrongPullUp, 1);
    overcurrentTrip = 1'b0;
    tick(20);
    check("fault held", faultLatched, 1);
    check("switch off", powerSwitchOn, 0);
    shutdownNInput = 1'b0;
    supplyAboveLockout = 1'b0;
    tick(10);
    check("fault cleared", faultLatched, 0);
    check("ref off", referenceEnable, 0);
    frequencySelect = 1'b1;
    bring_up();
    overTemp = 1'b1;
    wait_hi(4, 20, took);
    tick(2);
    check("ot ref kept", referenceEnable, 1);
    check("ot main off", mainEnable, 0);
    check("ot gate up", gateStrongPullUp, 1);
    overTemp = 1'b0;
    tick(20);
    check("ot fault held", faultLatched, 1);
    shutdownNInput = 1'b0;
    supplyAboveLockout = 1'b0;
    tick(10);
    check("ot cleared", faultLatched, 0);
    bring_up();
    supplyAboveLockout = 1'b0;
    wait_hi(4, 20, took);
    tick(2);
    check("uv pull-up", gateStrongPullUp, 1);
    check("uv osc", oscillatorEnable, 0);
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    tick(2);
    check("cycle clears", faultLatched, 0);
    give_verdict();
  end
endmodule
